//--- verilog/sci_consts.svh
// Offsets, field positions, reset values and masks of the SCI message enable block.
`ifndef SCI_CONSTS_SVH
`define SCI_CONSTS_SVH

// ------------------------------------------------------------
// Register indices and byte addresses
// ------------------------------------------------------------
`define SCI_EN_IDX 8'hce
`define SCI_PEND_IDX 8'hd0
`define SCI_EN_ADDR {22'h000000, `SCI_EN_IDX, 2'h0}
`define SCI_PEND_ADDR {22'h000000, `SCI_PEND_IDX, 2'h0}

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_RD_THROTTLE 15
`define BIT_WR_THROTTLE 14
`define BIT_CRIT_THERMAL 11
`define BIT_HILO_THERMAL 10
`define BIT_MULTI_ECC 1
`define BIT_SINGLE_ECC 0
`define STAT_VALID_BIT 16
`define STAT_SRC_LSB 20

// ------------------------------------------------------------
// Reset values and masks
// ------------------------------------------------------------
`define SCI_EN_RESET 16'h0000
`define SCI_EN_MASK 16'hcc03
`define HSIZE_WORD 3'h2

`endif

//--- verilog/sci_pkg.sv
// Types shared by the SCI message enable block.
package sci_pkg;
  typedef logic [15:0] err_vec_t;
  typedef logic [3:0] src_idx_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ, BUS_RDATA} bus_state_e;
  typedef enum logic {LINK_IDLE, LINK_SEND} link_state_e;
endpackage

//--- verilog/sci_msg_detect.sv
// Rising-edge detection of error status bits, qualified by the SCI enables.
module sci_msg_detect #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [W-1:0] status,
  input wire logic [W-1:0] enable,
  input wire logic [W-1:0] blocked,
  output logic [W-1:0] event_qual
);
  logic [W-1:0] prev_ff;
  logic [W-1:0] nxt_prev;

  // ------------------------------------------------------------
  // Previous status sampling
  // ------------------------------------------------------------
  always_comb begin
    nxt_prev = ce ? status : prev_ff;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  // ------------------------------------------------------------
  // Per-bit qualification
  // ------------------------------------------------------------
  // A condition already routed to SERR or SMI is dropped here, so one event never
  // produces two upstream messages.
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign event_qual[i] = ce & status[i] & ~prev_ff[i] & enable[i] & ~blocked[i];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  blocked_event_a: assert property ((blocked != '0) |-> ((event_qual & blocked) == '0))
    else $error("Event raised for a condition owned by SERR or SMI.");
  disabled_event_a: assert property (((event_qual & ~enable) == '0) && (ce || event_qual == '0))
    else $error("Event raised for a disabled condition or while frozen.");
  level_event_a: assert property (ce && (event_qual != '0) |=> ce |-> ((event_qual & $past(status)) == '0))
    else $error("A held status level raised a second event.");
endmodule

//--- verilog/sci_error_message_enable.sv
// SCI message enable register, event pending logic and upstream message launch.
`include "sci_consts.svh"

module sci_error_message_enable (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] error_status_reg,
  input wire logic [15:0] serr_error_enable,
  input wire logic [15:0] smi_error_enable,
  output logic sci_msg_valid,
  output logic [3:0] sci_msg_source,
  input wire logic sci_msg_ack
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  sci_pkg::bus_state_e bus_ff, nxt_bus;
  sci_pkg::link_state_e link_ff, nxt_link;
  logic [31:0] addr_ff, nxt_addr;
  logic size_ok_ff, nxt_size_ok;
  logic [31:0] rdata_ff, nxt_rdata;
  logic hready_ff, nxt_hready;
  logic hresp_ff;
  sci_pkg::err_vec_t en_ff, nxt_en;
  sci_pkg::err_vec_t pend_ff, nxt_pend;
  sci_pkg::err_vec_t qual;
  sci_pkg::err_vec_t eligible;
  sci_pkg::err_vec_t sw_clr;
  sci_pkg::err_vec_t link_clr;
  logic valid_ff, nxt_valid;
  sci_pkg::src_idx_t src_ff, nxt_src;
  logic accept;
  logic wr_commit;
  logic [31:0] read_mux;

  // Highest set bit wins: throttle events outrank thermal, thermal outranks ECC.
  function automatic sci_pkg::src_idx_t top_bit(input sci_pkg::err_vec_t v);
    sci_pkg::src_idx_t idx;
    idx = '0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // ------------------------------------------------------------
  // Event detection
  // ------------------------------------------------------------
  sci_msg_detect #(
    .W(16)
  ) u_detect (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .status(error_status_reg),
    .enable(en_ff),
    .blocked(serr_error_enable | smi_error_enable),
    .event_qual(qual)
  );

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  assign accept = hsel & htrans[1] & hready;
  assign wr_commit = (bus_ff == sci_pkg::BUS_WRITE) & size_ok_ff;

  always_comb begin
    read_mux = 32'h00000000;
    if (addr_ff == `SCI_EN_ADDR) begin
      read_mux = {16'h0000, en_ff};
    end else if (addr_ff == `SCI_PEND_ADDR) begin
      read_mux = {8'h00, src_ff, 3'h0, valid_ff, pend_ff};
    end
  end

  // Reads take one wait state so that the data is registered and a write just ahead
  // of the read is always seen.
  always_comb begin
    nxt_bus = bus_ff;
    nxt_addr = addr_ff;
    nxt_size_ok = size_ok_ff;
    nxt_rdata = rdata_ff;
    nxt_hready = hready_ff;
    unique case (bus_ff)
      sci_pkg::BUS_READ: begin
        nxt_rdata = read_mux;
        nxt_hready = 1'b1;
        nxt_bus = sci_pkg::BUS_RDATA;
      end
      sci_pkg::BUS_IDLE, sci_pkg::BUS_WRITE, sci_pkg::BUS_RDATA: begin
        if (accept) begin
          nxt_addr = {haddr[31:2], 2'h0};
          nxt_size_ok = (hsize == `HSIZE_WORD);
          nxt_bus = hwrite ? sci_pkg::BUS_WRITE : sci_pkg::BUS_READ;
          nxt_hready = hwrite;
        end else begin
          nxt_bus = sci_pkg::BUS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_ff <= sci_pkg::BUS_IDLE;
      addr_ff <= 32'h00000000;
      size_ok_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else if (ce) begin
      bus_ff <= nxt_bus;
      addr_ff <= nxt_addr;
      size_ok_ff <= nxt_size_ok;
      rdata_ff <= nxt_rdata;
      hready_ff <= nxt_hready;
      hresp_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Enable register and pending events
  // ------------------------------------------------------------
  always_comb begin
    nxt_en = en_ff;
    sw_clr = '0;
    if (wr_commit && addr_ff == `SCI_EN_ADDR) begin
      nxt_en = hwdata[15:0] & `SCI_EN_MASK;
    end
    if (wr_commit && addr_ff == `SCI_PEND_ADDR) begin
      sw_clr = hwdata[15:0];
    end
    // A new event wins over a clear in the same cycle; a disabled bit never stays pending.
    nxt_pend = ((pend_ff & ~sw_clr & ~link_clr) | qual) & nxt_en;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      en_ff <= `SCI_EN_RESET;
      pend_ff <= '0;
    end else if (ce) begin
      en_ff <= nxt_en;
      pend_ff <= nxt_pend;
    end
  end

  // ------------------------------------------------------------
  // Upstream message launch
  // ------------------------------------------------------------
  assign eligible = pend_ff & en_ff;

  always_comb begin
    nxt_link = link_ff;
    nxt_valid = valid_ff;
    nxt_src = src_ff;
    link_clr = '0;
    unique case (link_ff)
      sci_pkg::LINK_IDLE: begin
        if (eligible != '0) begin
          nxt_src = top_bit(eligible);
          link_clr[top_bit(eligible)] = 1'b1;
          nxt_valid = 1'b1;
          nxt_link = sci_pkg::LINK_SEND;
        end
      end
      sci_pkg::LINK_SEND: begin
        if (sci_msg_ack) begin
          nxt_valid = 1'b0;
          nxt_link = sci_pkg::LINK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      link_ff <= sci_pkg::LINK_IDLE;
      valid_ff <= 1'b0;
      src_ff <= '0;
    end else if (ce) begin
      link_ff <= nxt_link;
      valid_ff <= nxt_valid;
      src_ff <= nxt_src;
    end
  end

  assign hrdata = rdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = hresp_ff;
  assign sci_msg_valid = valid_ff;
  assign sci_msg_source = src_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  reset_clear_a: assert property (disable iff (1'b0) !reset_n |=> (en_ff == '0) && !sci_msg_valid)
    else $error("Enables or message not cleared by reset.");
  reserved_zero_a: assert property ((en_ff & ~`SCI_EN_MASK) == '0)
    else $error("Reserved enable bit is set.");
  enable_write_a: assert property (ce && wr_commit && addr_ff == `SCI_EN_ADDR
      |=> en_ff == ($past(hwdata[15:0]) & `SCI_EN_MASK))
    else $error("Enable register did not take the written value.");
  rd_throttle_a: assert property (ce && qual[15] && nxt_en[15] |=> pend_ff[15])
    else $error("Read-throttle event was not held for sending.");
  wr_throttle_a: assert property (ce && qual[14] && nxt_en[14] |=> pend_ff[14])
    else $error("Write-throttle event was not held for sending.");
  crit_thermal_a: assert property (ce && qual[11] && nxt_en[11] |=> pend_ff[11])
    else $error("Catastrophic thermal event was not held for sending.");
  hilo_thermal_a: assert property (ce && qual[10] && nxt_en[10] |=> pend_ff[10])
    else $error("High/low thermal event was not held for sending.");
  hilo_off_a: assert property (!en_ff[10] |-> !pend_ff[10] && !qual[10])
    else $error("Disabled high/low thermal condition is pending.");
  multi_ecc_a: assert property (ce && qual[1] && nxt_en[1] |=> pend_ff[1])
    else $error("Multiple-bit ECC event was not held for sending.");
  single_ecc_a: assert property (ce && qual[0] && nxt_en[0] |=> pend_ff[0])
    else $error("Single-bit ECC event was not held for sending.");
  launch_once_a: assert property (ce && link_ff == sci_pkg::LINK_IDLE && eligible != '0
      |=> sci_msg_valid && !(pend_ff[sci_msg_source] && !$past(qual[top_bit(eligible)])))
    else $error("Launched condition stayed pending after its message.");
  msg_hold_a: assert property (sci_msg_valid && !(ce && sci_msg_ack)
      |=> sci_msg_valid && $stable(sci_msg_source))
    else $error("Message dropped or changed before acknowledge.");
  read_wait_a: assert property (ce && accept && !hwrite
      |=> !hreadyout ##1 hreadyout)
    else $error("Read did not take exactly one wait state.");

  msg_sent_c: cover property (sci_msg_valid && sci_msg_ack && ce);
  hilo_msg_c: cover property (sci_msg_valid && sci_msg_source == 4'ha);
  back_to_back_c: cover property (ce && sci_msg_ack ##1 sci_msg_valid [*2]);
  enable_read_c: cover property (bus_ff == sci_pkg::BUS_READ && addr_ff == `SCI_EN_ADDR);
endmodule

//--- tb/hub_rx_model.sv
// Behavioural model of the upstream hub that accepts SCI messages.
module hub_rx_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic msg_valid,
  input wire logic [3:0] msg_source,
  output logic msg_ack,
  output logic got,
  output logic [3:0] got_src
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_ff;
  // A slow hub lets the offer stand several cycles, so merging and ordering are exercised.
  always @(posedge clk) begin
    got <= 1'b0;
    if (!reset_n) begin
      msg_ack <= 1'b0;
      wait_ff <= 2'h0;
      got_src <= 4'h0;
    end else if (msg_valid && msg_ack) begin
      msg_ack <= 1'b0;
      got <= 1'b1;
      got_src <= msg_source;
      wait_ff <= 2'h0;
    end else if (msg_valid) begin
      if (!slow || wait_ff == 2'h3) msg_ack <= 1'b1;
      else wait_ff <= wait_ff + 2'h1;
    end
  end
endmodule

//--- tb/tb.sv
// Self-checking bench of the SCI message enable block.
`include "sci_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = `HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [15:0] status = 16'h0;
  logic [15:0] serr_en = 16'h0;
  logic [15:0] smi_en = 16'h0;
  logic msg_valid;
  logic msg_ack;
  logic slow = 1'b0;
  logic got;
  logic [3:0] msg_source;
  logic [3:0] got_src;
  logic [31:0] rd;
  logic [31:0] v;
  int fails = 0;
  int n_compared = 0;
  logic [3:0] exp_q[$];
  logic [3:0] bits_tab [6] = '{4'hf, 4'he, 4'hb, 4'ha, 4'h1, 4'h0};
  always #5 clk = ~clk;
  sci_error_message_enable dut_u (
    .clk(clk), .reset_n(reset_n), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .error_status_reg(status), .serr_error_enable(serr_en),
    .smi_error_enable(smi_en), .sci_msg_valid(msg_valid),
    .sci_msg_source(msg_source), .sci_msg_ack(msg_ack)
  );
  hub_rx_model hub_u (
    .clk(clk), .reset_n(reset_n), .slow(slow), .msg_valid(msg_valid),
    .msg_source(msg_source), .msg_ack(msg_ack), .got(got), .got_src(got_src)
  );
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    cmp("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    cmp(nm, e, rd);
  endtask
  // The hold of several cycles proves that a level does not repeat its message.
  task automatic pulse(input logic [15:0] st);
    int k;
    status <= st;
    repeat (6) @(posedge clk);
    status <= 16'h0;
    k = 0;
    while (exp_q.size() != 0 && k < 300) begin
      @(posedge clk);
      k++;
    end
    if (exp_q.size() != 0) begin
      fails++;
      give_verdict();
    end
    repeat (10) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) cmp("extra_msg", 32'h0, 32'h1);
      else cmp("msg_source", {28'h0, exp_q.pop_front()}, {28'h0, got_src});
    end
  end
  initial begin
    v = $urandom(20032);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rchk("en_reset", `SCI_EN_ADDR, 32'h0);
    rchk("pend_reset", `SCI_PEND_ADDR, 32'h0);
    ahb(1'b1, 32'h100, 32'hffffffff);
    rchk("unmapped", 32'h100, 32'h0);
    repeat (4) begin
      v = $urandom;
      ahb(1'b1, `SCI_EN_ADDR, v);
      rchk("en_masked", `SCI_EN_ADDR, v & {16'h0, `SCI_EN_MASK});
    end
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      ahb(1'b1, `SCI_EN_ADDR, 32'h1 << bits_tab[i]);
      exp_q.push_back(bits_tab[i]);
      pulse(16'h1 << bits_tab[i]);
    end
    ahb(1'b1, `SCI_EN_ADDR, 32'h0);
    pulse(16'hcc03);
    ahb(1'b1, `SCI_EN_ADDR, 32'hffff);
    slow <= 1'b1;
    exp_q.push_back(4'hb);
    exp_q.push_back(4'ha);
    pulse(16'h3ffc);
    // Bit 10 stays out of both SERR and SMI while its SCI enable is on.
    serr_en <= 16'h8800;
    smi_en <= 16'h4003;
    exp_q.push_back(4'ha);
    pulse(16'hcc03);
    serr_en <= 16'h0;
    smi_en <= 16'h0;
    exp_q.push_back(4'hf);
    exp_q.push_back(4'h0);
    pulse(16'h8001);
    rchk("pend_idle", `SCI_PEND_ADDR, 32'h0);
    give_verdict();
  end
endmodule
